// ---- core/logger_regs.svh ----
// Purpose: Register offsets, field positions, reset values and timing
//          constants of the periodic register snapshot logger.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Byte offsets; every unlisted offset answers with an error.
`ifndef LOGGER_REGS_SVH
`define LOGGER_REGS_SVH

// ==========================================================
// Register offsets
`define OFS_MODE       8'h00
`define OFS_INTERVAL   8'h04
`define OFS_ERASE      8'h08
`define OFS_STATUS     8'h0C
`define OFS_ENTRIES    8'h10
`define OFS_ENTRY_LEN  8'h14
`define OFS_REFUSED    8'h18
`define OFS_DESC_BASE  8'h40
`define OFS_DESC_LAST  8'h7C

// ==========================================================
// Field positions and values
`define MODE_W         2
`define DESC_CNT_LSB   16
`define DESC_CNT_MSB   22
`define ST_PRESENT     0
`define ST_FULL        1
`define ST_BUSY        2
`define ST_WRAPPED     3
`define ERASE_KEY      32'h0000A5A5
`define INTERVAL_RST   32'h00000001
`define INTERVAL_MIN   32'h00000001
`define INTERVAL_MAX   32'h0000FD20
`define MAX_BLK_REGS   7'h7D
`define NUM_BLOCKS     16
`define LOG_WORDS      21'h100000

// ==========================================================
// Timing
`define SECOND_NS      1000000000
`define CLK_NS         8
`define SEC_CYCLES     (`SECOND_NS / `CLK_NS)

`endif

// ---- core/logger_pkg.sv ----
// Purpose: Types shared by the snapshot logger and its bench.
// Assumes: Nothing beyond the constants header.
// Notes:   Mode codes are fixed by the register encoding.
package logger_pkg;

  // ==========================================================
  // Logging mode, encoded as written by software
  typedef enum logic [1:0]
  {
    MODE_OFF = 2'h0,
    MODE_CIRCULAR = 2'h1,
    MODE_UNTIL_FULL = 2'h2
  } log_mode_t;

  // One captured block: first register and number of registers
  typedef struct packed
  {
    logic [6:0] count;
    logic [15:0] start;
  } block_desc_t;

  // One word headed for log storage
  typedef struct packed
  {
    logic [19:0] addr;
    logic [15:0] data;
  } flash_word_t;

  // Capture sequencer states
  typedef enum logic [1:0]
  {
    CAP_IDLE,
    CAP_SCAN,
    CAP_READ,
    CAP_WRITE
  } cap_state_t;

endpackage

// ---- core/snapshot_logger.sv ----
// Purpose: Configuration and capture controller of a periodic register
//          logger, reached over APB.
// Assumes: Register map read port and log storage port on pclk.
// Notes:   The summary below lists the rules that the logic keeps.
// Summary of operation
// - Only descriptors require disabled and empty to change
// - Interval writable whenever logging is disabled
// - Block list changes only while the log is empty
// - Interval from 1 to 64800 seconds
// - Multi-block entries within one second
// - Sixteen block descriptors at most
// - No block larger than 125 registers
// - Descriptor holds start address and count
// - Stop-when-full or circular overwrite mode
// - Any register capturable, stored as entries
// - Mode codes: 0 off, 1 circular, 2 full
// - Erase key 0xA5A5 wipes the log
// - Interval is 32-bit count of seconds
`timescale 1ns/100ps
`include "logger_regs.svh"

module snapshot_logger
  import logger_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES
)
(
  input wire logic pclk, // System clock, 125 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error: unmapped or refused
  output logic src_req, // Register map read request
  output logic [15:0] src_addr, // Register map address
  input wire logic src_ack, // Register map answer valid
  input wire logic [15:0] src_data, // Register map answer
  output logic flash_valid, // Log storage write request
  output flash_word_t flash_word, // Log storage address and data
  input wire logic flash_ready, // Log storage accepts word
  output logic flash_erase // Log storage wipe, one cycle
);

  // ==========================================================
  // State of both groups
  log_mode_t mode, next_mode;
  logic [31:0] interval, next_interval;
  block_desc_t desc [`NUM_BLOCKS];
  block_desc_t next_desc [`NUM_BLOCKS];
  logic refused, next_refused;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_flash_erase;
  cap_state_t state, next_state;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [31:0] sec_cnt, next_sec_cnt;
  logic [3:0] blk, next_blk;
  logic [6:0] ofs, next_ofs;
  logic [20:0] wr_ptr, next_wr_ptr;
  logic [31:0] entries, next_entries;
  logic present, next_present;
  logic full, next_full;
  logic wrapped, next_wrapped;
  logic stop_req, next_stop_req;
  logic next_src_req, next_flash_valid;
  logic [15:0] next_src_addr;
  flash_word_t next_flash_word;
  logic [11:0] entry_len;
  logic wr_commit, setup_cyc, cfg_open, desc_hit;
  logic [3:0] desc_idx;

  // Entry length summed over all descriptors, and bus decode
  always_comb
  begin
    entry_len = 12'h000;
    for (int i = 0; i < `NUM_BLOCKS; i++)
      entry_len = entry_len + {5'h00, desc[i].count};
    setup_cyc = psel && !penable;
    wr_commit = psel && penable && pready && pwrite;
    desc_hit = (paddr >= `OFS_DESC_BASE) && (paddr <= `OFS_DESC_LAST)
      && (paddr[1:0] == 2'h0);
    desc_idx = paddr[5:2];
    cfg_open = (mode == MODE_OFF) && !present;
  end

  // ==========================================================
  // Config group: APB slave and configuration registers
  // Answers come one cycle after setup; refused writes raise pslverr
  always_comb
  begin
    next_mode = mode;
    next_interval = interval;
    next_desc = desc;
    next_refused = refused;
    next_flash_erase = 1'b0;
    next_pready = setup_cyc;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    // Decide the answer during setup so that it leaves a flop
    if (setup_cyc)
    begin
      case (paddr)
        `OFS_MODE:
          begin
            next_prdata = {30'h00000000, mode};
            next_pslverr = pwrite && (pwdata > 32'h00000002);
          end
        `OFS_INTERVAL:
          begin
            next_prdata = interval;
            next_pslverr = pwrite && ((mode != MODE_OFF)
              || (pwdata < `INTERVAL_MIN) || (pwdata > `INTERVAL_MAX));
          end
        `OFS_ERASE: next_prdata = 32'h00000000;
        `OFS_STATUS:
          begin
            next_prdata[`ST_PRESENT] = present;
            next_prdata[`ST_FULL] = full;
            next_prdata[`ST_BUSY] = (state != CAP_IDLE);
            next_prdata[`ST_WRAPPED] = wrapped;
            next_pslverr = pwrite;
          end
        `OFS_ENTRIES:
          begin
            next_prdata = entries;
            next_pslverr = pwrite;
          end
        `OFS_ENTRY_LEN:
          begin
            next_prdata = {20'h00000, entry_len};
            next_pslverr = pwrite;
          end
        `OFS_REFUSED: next_prdata = {31'h00000000, refused};
        default:
          begin
            if (desc_hit)
            begin
              next_prdata = {9'h000, desc[desc_idx]};
              next_pslverr = pwrite && (!cfg_open
                || (pwdata[`DESC_CNT_MSB:`DESC_CNT_LSB]
                > `MAX_BLK_REGS));
            end
            else
              next_pslverr = 1'b1;
          end
      endcase
    end
    // Commit on the access edge, never when the answer was an error
    if (wr_commit && !pslverr)
    begin
      case (paddr)
        `OFS_MODE: next_mode = log_mode_t'(pwdata[1:0]);
        `OFS_INTERVAL: next_interval = pwdata;
        `OFS_ERASE: next_flash_erase = (pwdata == `ERASE_KEY);
        `OFS_REFUSED:
          if (pwdata[0])
            next_refused = 1'b0;
        default:
          if (desc_hit)
          begin
            next_desc[desc_idx].start = pwdata[15:0];
            next_desc[desc_idx].count =
              pwdata[`DESC_CNT_MSB:`DESC_CNT_LSB];
          end
      endcase
    end
    // A refused write sets the flag even while software clears it
    if (psel && penable && pready && pwrite && pslverr)
      next_refused = 1'b1;
    // Full in stop mode drops back to disabled, over any mode write
    if (stop_req)
      next_mode = MODE_OFF;
  end

  // Register the config group
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= MODE_OFF;
      interval <= `INTERVAL_RST;
      desc <= '{default: '0};
      refused <= 1'b0;
      flash_erase <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      interval <= next_interval;
      desc <= next_desc;
      refused <= next_refused;
      flash_erase <= next_flash_erase;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Capture group: second timer and entry sequencer
  // Timer restarts whenever logging is off, so the first entry lands
  // one full interval after enabling
  always_comb
  begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_sec_cnt = sec_cnt;
    next_blk = blk;
    next_ofs = ofs;
    next_wr_ptr = wr_ptr;
    next_entries = entries;
    next_present = present;
    next_full = full;
    next_wrapped = wrapped;
    next_stop_req = 1'b0;
    next_src_req = src_req;
    next_src_addr = src_addr;
    next_flash_valid = flash_valid;
    next_flash_word = flash_word;
    if (mode == MODE_OFF)
    begin
      next_tick_cnt = 32'h00000000;
      next_sec_cnt = 32'h00000000;
    end
    else if (tick_cnt == SEC_CYCLES - 1)
    begin
      next_tick_cnt = 32'h00000000;
      next_sec_cnt = sec_cnt + 32'h00000001;
    end
    else
      next_tick_cnt = tick_cnt + 32'h00000001;
    case (state)
      CAP_IDLE:
        // Due entry; one that falls while busy starts on return to idle
        if ((mode != MODE_OFF) && (sec_cnt >= interval))
        begin
          next_sec_cnt = 32'h00000000;
          next_blk = 4'h0;
          next_ofs = 7'h00;
          if (entry_len == 12'h000)
            next_state = CAP_IDLE;
          else if ((wr_ptr + {9'h000, entry_len}) <= `LOG_WORDS)
            next_state = CAP_SCAN;
          else if (mode == MODE_UNTIL_FULL)
          begin
            next_full = 1'b1;
            next_stop_req = 1'b1;
          end
          else
          begin
            next_wr_ptr = 21'h000000;
            next_wrapped = 1'b1;
            next_state = CAP_SCAN;
          end
        end
      CAP_SCAN:
        // Walk descriptors in order, skipping empty or finished ones
        if (ofs < desc[blk].count)
        begin
          next_src_req = 1'b1;
          next_src_addr = desc[blk].start + {9'h000, ofs};
          next_state = CAP_READ;
        end
        else if (blk == 4'hF)
        begin
          next_entries = entries + 32'h00000001;
          next_present = 1'b1;
          next_state = CAP_IDLE;
        end
        else
        begin
          next_blk = blk + 4'h1;
          next_ofs = 7'h00;
        end
      CAP_READ:
        if (src_ack)
        begin
          next_src_req = 1'b0;
          next_flash_valid = 1'b1;
          next_flash_word.addr = wr_ptr[19:0];
          next_flash_word.data = src_data;
          next_state = CAP_WRITE;
        end
      CAP_WRITE:
        // Storage back-pressure stalls the whole entry
        if (flash_ready)
        begin
          next_flash_valid = 1'b0;
          next_wr_ptr = wr_ptr + 21'h000001;
          next_ofs = ofs + 7'h01;
          next_state = CAP_SCAN;
        end
      default: next_state = CAP_IDLE;
    endcase
    // Erase returns storage to its start only while idle; during an entry the pointer and counts are kept
    if (flash_erase && (state == CAP_IDLE))
    begin
      next_wr_ptr = 21'h000000;
      next_entries = 32'h00000000;
      next_present = 1'b0;
      next_full = 1'b0;
      next_wrapped = 1'b0;
    end
  end

  // Register the capture group
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CAP_IDLE;
      tick_cnt <= 32'h00000000;
      sec_cnt <= 32'h00000000;
      blk <= 4'h0;
      ofs <= 7'h00;
      wr_ptr <= 21'h000000;
      entries <= 32'h00000000;
      present <= 1'b0;
      full <= 1'b0;
      wrapped <= 1'b0;
      stop_req <= 1'b0;
      src_req <= 1'b0;
      src_addr <= 16'h0000;
      flash_valid <= 1'b0;
      flash_word <= '0;
    end
    else
    begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      sec_cnt <= next_sec_cnt;
      blk <= next_blk;
      ofs <= next_ofs;
      wr_ptr <= next_wr_ptr;
      entries <= next_entries;
      present <= next_present;
      full <= next_full;
      wrapped <= next_wrapped;
      stop_req <= next_stop_req;
      src_req <= next_src_req;
      src_addr <= next_src_addr;
      flash_valid <= next_flash_valid;
      flash_word <= next_flash_word;
    end
  end

endmodule

// ---- dv/logger_far_model.sv ----
// Purpose: Register map and log storage seen from the logger.
// Assumes: Same clock as the logger.
// Notes:   Stored words are kept for the bench to inspect.
`timescale 1ns/100ps
module logger_far_model
  import logger_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic src_req, // Read request
  input wire logic [15:0] src_addr, // Read address
  output logic src_ack, // Read answer
  output logic [15:0] src_data, // Read data
  input wire logic flash_valid, // Store request
  input wire flash_word_t flash_word, // Store word
  output logic flash_ready // Store accept
);
  // ==========================================================
  // Record of stored words
  logic [19:0] fa [0:63];
  logic [15:0] fd [0:63];
  int fs [0:63];
  int n;
  int cyc;
  logic [1:0] wt;

  // Reads alternate prompt and slow; data toggles when not answered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_ack <= 1'b0;
      src_data <= 16'h0000;
      flash_ready <= 1'b0;
      wt <= 2'h0;
      n <= 0;
      cyc <= 0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (src_req && !src_ack && wt == 2'h0)
      begin
        src_ack <= 1'b1;
        src_data <= src_addr ^ 16'h5A5A;
        wt <= {n[0], 1'b0};
      end
      else
      begin
        src_ack <= 1'b0;
        src_data <= ~src_data;
        if (src_req && !src_ack)
          wt <= wt - 2'h1;
      end
      // Storage stalls on odd cycles
      if (flash_valid && flash_ready)
      begin
        fa[n[5:0]] <= flash_word.addr;
        fd[n[5:0]] <= flash_word.data;
        fs[n[5:0]] <= cyc;
        n <= n + 1;
        flash_ready <= 1'b0;
      end
      else if (flash_valid)
        flash_ready <= cyc[0];
    end
  end
endmodule

// ---- dv/snapshot_logger_asserts.sv ----
// Purpose: Port checks of the snapshot logger.
// Assumes: One clock domain, reset asynchronous active low.
// Notes:   Attached to every logger instance by bind.
`timescale 1ns/100ps
`include "logger_regs.svh"
module snapshot_logger_asserts
  import logger_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic src_req, // Read request
  input wire logic [15:0] src_addr, // Read address
  input wire logic src_ack, // Read answer
  input wire logic [15:0] src_data, // Read data
  input wire logic flash_valid, // Store request
  input wire flash_word_t flash_word, // Store word
  input wire logic flash_ready, // Store accept
  input wire logic flash_erase // Wipe pulse
);
  // ==========================================================
  // Helper terms
  logic setup_wr;
  logic key_wr;
  assign setup_wr = psel && !penable && pwrite;
  assign key_wr = psel && penable && pwrite && paddr == `OFS_ERASE &&
    pwdata == `ERASE_KEY;

  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_MODE_BAD: assert property (
    setup_wr && paddr == `OFS_MODE && pwdata > 32'h00000002 |=> pslverr)
    else $error("bad mode accepted");
  AST_IVL_BAD: assert property (setup_wr && paddr == `OFS_INTERVAL &&
    (pwdata == 32'h0 || pwdata > `INTERVAL_MAX) |=> pslverr)
    else $error("bad interval accepted");
  AST_ERASE_SRC: assert property (flash_erase |-> $past(key_wr))
    else $error("wipe without key");
  AST_ERASE_ONE: assert property (flash_erase |=> !flash_erase)
    else $error("wipe longer than one cycle");
  AST_SRC_HOLD: assert property (
    src_req && !src_ack |=> src_req && $stable(src_addr))
    else $error("read request dropped");
  AST_FLASH_HOLD: assert property (
    flash_valid && !flash_ready |=> flash_valid && $stable(flash_word))
    else $error("store request dropped");
  AST_DATA: assert property (src_req && src_ack |=>
    flash_valid && flash_word.data == $past(src_data))
    else $error("stored data differs");
  AST_EXCL: assert property (!(src_req && flash_valid))
    else $error("read and store overlap");
endmodule

bind snapshot_logger snapshot_logger_asserts chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .src_req,
  .src_addr, .src_ack, .src_data, .flash_valid, .flash_word,
  .flash_ready, .flash_erase);

// ---- dv/snapshot_logger_tb_top.sv ----
// Purpose: Self-checking bench of the snapshot logger.
// Assumes: Short second of SC cycles.
// Notes:   Storage capacity too large to fill here.
`timescale 1ns/100ps
`include "logger_regs.svh"
module snapshot_logger_tb_top
  import logger_pkg::*;
;
  localparam int SC = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic src_req, src_ack, flash_valid, flash_ready, flash_erase;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] src_addr, src_data;
  flash_word_t flash_word;
  int error_cnt, n_tests, cycles;

  snapshot_logger #(.SEC_CYCLES(SC)) DUT (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_req, .src_addr, .src_ack, .src_data, .flash_valid,
    .flash_word, .flash_ready, .flash_erase);
  logger_far_model M (.pclk, .presetn, .src_req, .src_addr, .src_ack,
    .src_data, .flash_valid, .flash_word, .flash_ready);

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] e, g);
  begin
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s @%h expected %h seen %h", what, paddr, e, g);
    end
  end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input
    logic [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input
    logic e);
  begin
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, e}, {31'h0, er});
  end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
  end
  endtask

  task automatic present(input logic e);
  begin
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("present", {31'h0, e}, {31'h0, rd[`ST_PRESENT]});
  end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
  begin
    rdc(`OFS_MODE, 32'h0);
    rdc(`OFS_INTERVAL, `INTERVAL_RST);
    rdc(`OFS_REFUSED, 32'h0);
    rdc(`OFS_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b0, 8'h80, 32'h0);
    chk("desc 16", 32'h1, {31'h0, er});
    $display("test reset done");
  end
  endtask

  task automatic t_refuse;
  begin
    wr(`OFS_INTERVAL, 32'h0, 1'b1);
    wr(`OFS_INTERVAL, 32'h0000FD21, 1'b1);
    wr(`OFS_INTERVAL, `INTERVAL_MAX, 1'b0);
    rdc(`OFS_INTERVAL, 32'h0000FD20);
    wr(`OFS_MODE, 32'h3, 1'b1);
    wr(`OFS_DESC_BASE + 8'h4, 32'h007E0000, 1'b1);
    wr(`OFS_DESC_BASE + 8'h4, 32'h007D0000, 1'b0);
    rdc(`OFS_REFUSED, 32'h1);
    wr(`OFS_REFUSED, 32'h1, 1'b0);
    rdc(`OFS_REFUSED, 32'h0);
    wr(`OFS_STATUS, 32'h0, 1'b1);
    wr(`OFS_DESC_BASE + 8'h4, 32'h0, 1'b0);
    $display("test refuse done");
  end
  endtask

  task automatic t_capture;
    logic [15:0] ea [0:2];
  begin
    ea = '{16'h0200, 16'h0201, 16'h1100};
    wr(`OFS_DESC_BASE, 32'h00020200, 1'b0);
    wr(`OFS_DESC_LAST, 32'h00011100, 1'b0);
    rdc(`OFS_ENTRY_LEN, 32'h3);
    rdc(`OFS_DESC_BASE, 32'h00020200);
    wr(`OFS_INTERVAL, 32'h1, 1'b0);
    wr(`OFS_MODE, 32'h2, 1'b0);
    wr(`OFS_INTERVAL, 32'h1, 1'b1);
    while (M.n < 6) @(posedge pclk);
    for (int i = 0; i < 6; i++)
    begin
      chk("store addr", i, {12'h0, M.fa[i]});
      chk("store data", {16'h0, ea[i % 3] ^ 16'h5A5A}, M.fd[i]);
    end
    wr(`OFS_MODE, 32'h0, 1'b0);
    do apb(1'b0, `OFS_STATUS, 32'h0); while (rd[`ST_BUSY] !== 1'b0);
    rdc(`OFS_STATUS, 32'h1);
    rdc(`OFS_ENTRIES, M.n / 3);
    wr(`OFS_DESC_BASE, 32'h00010300, 1'b1);
    wr(`OFS_INTERVAL, 32'h2, 1'b0);
    present(1'b1);
    wr(`OFS_ERASE, 32'h00005A5A, 1'b0);
    present(1'b1);
    wr(`OFS_ERASE, `ERASE_KEY, 1'b0);
    present(1'b0);
    rdc(`OFS_ENTRIES, 32'h0);
    wr(`OFS_DESC_BASE, 32'h00020200, 1'b0);
    $display("test capture done");
  end
  endtask

  task automatic t_circ;
    int k;
    int g;
    int t0;
  begin
    k = M.n;
    t0 = M.cyc;
    wr(`OFS_MODE, 32'h1, 1'b0);
    while (M.n < k + 6) @(posedge pclk);
    chk("restart addr", 32'h0, {12'h0, M.fa[k]});
    g = M.fs[k] - t0;
    chk("first due", 32'h1, {31'h0, g >= 2 * SC && g <= 2 * SC + 20});
    g = M.fs[k + 3] - M.fs[k];
    chk("gap", 32'h1, {31'h0, g >= SC && g <= 3 * SC});
    wr(`OFS_MODE, 32'h0, 1'b0);
    $display("test circular done");
  end
  endtask

  // ==========================================================
  // Verdict, clock, timeout and main sequence
  task automatic finish_test;
  begin
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Cuts a hang short
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("Error timeout expected done seen hang");
      finish_test;
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_refuse;
    t_capture;
    t_circ;
    finish_test;
  end
endmodule
